// ---- verilog/vcsc_defs.svh ----
// Constants of the colour conversion, scaling and hue stage.
// Assumes 8-bit register addresses and 8-bit pixel components.
`ifndef VCSC_DEFS_SVH
`define VCSC_DEFS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define VCSC_A_MODE 8'h01
`define VCSC_A_OUTCTL 8'h02
`define VCSC_A_GY_LO 8'h03
`define VCSC_A_PACK_LO 8'h04
`define VCSC_A_GY_HI 8'h05
`define VCSC_A_GU_HI 8'h06
`define VCSC_A_GV_HI 8'h07
`define VCSC_A_BU_HI 8'h08
`define VCSC_A_RV_HI 8'h09
`define VCSC_A_PATCTL 8'h31
`define VCSC_A_EDCTL 8'h35
`define VCSC_A_PAT0 8'h36
`define VCSC_A_PAT1 8'h37
`define VCSC_A_PAT2 8'h38
`define VCSC_A_SDCTL 8'h87
`define VCSC_A_SCL_LO 8'h9c
`define VCSC_A_SCL_Y 8'h9d
`define VCSC_A_SCL_CB 8'h9e
`define VCSC_A_SCL_CR 8'h9f
`define VCSC_A_HUE 8'ha0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define VCSC_B_OUT_YPRPB 5
`define VCSC_B_SYNC_RGB 4
`define VCSC_B_MANUAL 3
`define VCSC_B_PAT_EN 2
`define VCSC_B_ED_RGB_IN 1
`define VCSC_B_SYNC_PRPB 2
`define VCSC_B_SD_RGB_IN 7
`define VCSC_B_HUE_EN 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define VCSC_R_GY_LO 8'h03
`define VCSC_R_PACK_LO 8'hf0
`define VCSC_R_GY_HI 8'h4e
`define VCSC_R_GU_HI 8'h0e
`define VCSC_R_GV_HI 8'h24
`define VCSC_R_BU_HI 8'h92
`define VCSC_R_RV_HI 8'h7c
`define VCSC_R_SCALE 8'h80
`define VCSC_R_HUE 8'h80
// ----------------------------------------
// Arithmetic constants
// ----------------------------------------
`define VCSC_COEF_UNITY 24'sh13b
`define VCSC_SCALE_SHIFT 9
`define VCSC_MID 8'h80
`define VCSC_PAL_HUE_MIN 8'h01
`endif

// ---- verilog/vcsc_pkg.sv ----
// Types shared by both ends of the colour stage.
// Assumes vcsc_defs.svh for all numeric constants.
package vcsc_pkg;
  typedef logic [7:0] vcsc_byte_type;
  typedef logic [9:0] vcsc_coef_type;
  typedef enum logic [4:0] {
    VCSC_SRC_IDLE = 5'h01,
    VCSC_SRC_WRITE = 5'h02,
    VCSC_SRC_SEQ = 5'h04,
    VCSC_SRC_READ = 5'h08,
    VCSC_SRC_WAIT = 5'h10
  } vcsc_src_state_type;
endpackage

// ---- verilog/vcsc_if.sv ----
// Link between the pixel source and the colour stage.
// Assumes both ends share clk and rst_b.
`timescale 1ns/100ps
interface vcsc_if (
  input wire logic clk,
  input wire logic rst_b
);
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic pix_valid;
  logic pix_ready;
  logic pix_active;
  logic [23:0] pix_data;
  modport device (
    input clk, rst_b, reg_wr, reg_rd, reg_addr, reg_wdata,
    input pix_valid, pix_active, pix_data,
    output reg_rdata, reg_rvalid, pix_ready
  );
  modport source (
    input clk, rst_b, reg_rdata, reg_rvalid, pix_ready,
    output reg_wr, reg_rd, reg_addr, reg_wdata,
    output pix_valid, pix_active, pix_data
  );
endinterface

// ---- verilog/vcsc_core.sv ----
// Colour stage: test colours, conversion matrix, SD scaling and hue.
// Assumes pixels as {c0,c1,c2} = {Y,Cr,Cb} or {R,G,B}; one clock domain.
//
// Functional notes
// - Pattern enable outputs the three test colours, in ED/HD modes only.
// - Test colours never touch external pixels.
// - Conversion chosen from mode field automatically.
// - SD supports all four input/output combinations.
// - ED/HD never converts RGB input to YPrPb.
// - Composite and luma/chroma outputs available in SD modes only.
// - Manual ED/HD coefficients, off after reset.
// - Manual RGB output uses five-coefficient equations.
// - Manual YPrPb output multiplies each component.
// - Coefficients are 8 high plus 2 low bits.
// - Matrix registers reset to HD coefficients.
// - Software scales coefficients by 315.
// - Matrix bypassed while test pattern enabled in ED/HD modes.
// - Software follows manual RGB programming order.
// - SD scale factor is value over 512.
// - SD scale high bytes separate, low bits shared.
// - SD scaling reaches every SD output.
// - Hue shift during active SD video when enabled.
// - Hue shift step is value minus 128.
// - Software keeps PAL hue at least 0x01.
// - Software may use sample test colours.
`timescale 1ns/100ps
`include "vcsc_defs.svh"
module vcsc_core #(
  parameter int DEPTH = 2
) (
  vcsc_if.device bus,
  input wire logic out_ready,
  output logic out_valid,
  output logic [23:0] out_data,
  output logic out_is_rgb,
  output logic [23:0] sd_ycc,
  output logic [7:0] hue_step
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("DEPTH must be a power of two, at least 2.");
  end
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] regs_q [0:255];
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `VCSC_A_MODE, `VCSC_A_OUTCTL, `VCSC_A_PATCTL, `VCSC_A_EDCTL,
      `VCSC_A_PAT0, `VCSC_A_PAT1, `VCSC_A_PAT2, `VCSC_A_SDCTL,
      `VCSC_A_HUE: mapped = 1'b1;
      default: mapped = (a >= `VCSC_A_GY_LO && a <= `VCSC_A_RV_HI) ||
                        (a >= `VCSC_A_SCL_LO && a <= `VCSC_A_SCL_CR);
    endcase
  endfunction
  function automatic logic [7:0] reset_val(input logic [7:0] a);
    case (a)
      `VCSC_A_GY_LO: reset_val = `VCSC_R_GY_LO;
      `VCSC_A_PACK_LO: reset_val = `VCSC_R_PACK_LO;
      `VCSC_A_GY_HI: reset_val = `VCSC_R_GY_HI;
      `VCSC_A_GU_HI: reset_val = `VCSC_R_GU_HI;
      `VCSC_A_GV_HI: reset_val = `VCSC_R_GV_HI;
      `VCSC_A_BU_HI: reset_val = `VCSC_R_BU_HI;
      `VCSC_A_RV_HI: reset_val = `VCSC_R_RV_HI;
      `VCSC_A_SCL_Y, `VCSC_A_SCL_CB,
      `VCSC_A_SCL_CR: reset_val = `VCSC_R_SCALE;
      `VCSC_A_HUE: reset_val = `VCSC_R_HUE;
      default: reset_val = 8'h00;
    endcase
  endfunction
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= reset_val(8'(i));
      end
    end else if (bus.reg_wr && mapped(bus.reg_addr)) begin
      regs_q[bus.reg_addr] <= bus.reg_wdata;
    end
  end
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      bus.reg_rdata <= 8'h00;
      bus.reg_rvalid <= 1'b0;
    end else begin
      bus.reg_rvalid <= bus.reg_rd;
      bus.reg_rdata <= (bus.reg_rd && mapped(bus.reg_addr)) ?
                       regs_q[bus.reg_addr] : 8'h00;
    end
  end
  // ----------------------------------------
  // Decoded controls
  // ----------------------------------------
  logic sd_mode, out_yprpb, manual, pat_en, ed_rgb_in, sd_rgb_in, hue_en;
  vcsc_pkg::vcsc_coef_type gy, gu, gv, bu, rv, sy, scb, scr;
  assign sd_mode = regs_q[`VCSC_A_MODE][6:4] == 3'h0;
  assign out_yprpb = regs_q[`VCSC_A_OUTCTL][`VCSC_B_OUT_YPRPB];
  assign manual = regs_q[`VCSC_A_OUTCTL][`VCSC_B_MANUAL];
  assign pat_en = regs_q[`VCSC_A_PATCTL][`VCSC_B_PAT_EN];
  assign ed_rgb_in = regs_q[`VCSC_A_EDCTL][`VCSC_B_ED_RGB_IN];
  assign sd_rgb_in = regs_q[`VCSC_A_SDCTL][`VCSC_B_SD_RGB_IN];
  assign hue_en = regs_q[`VCSC_A_SDCTL][`VCSC_B_HUE_EN];
  assign gy = {regs_q[`VCSC_A_GY_HI], regs_q[`VCSC_A_GY_LO][1:0]};
  assign gu = {regs_q[`VCSC_A_GU_HI], regs_q[`VCSC_A_PACK_LO][7:6]};
  assign gv = {regs_q[`VCSC_A_GV_HI], regs_q[`VCSC_A_PACK_LO][5:4]};
  assign bu = {regs_q[`VCSC_A_BU_HI], regs_q[`VCSC_A_PACK_LO][3:2]};
  assign rv = {regs_q[`VCSC_A_RV_HI], regs_q[`VCSC_A_PACK_LO][1:0]};
  assign sy = {regs_q[`VCSC_A_SCL_Y], regs_q[`VCSC_A_SCL_LO][1:0]};
  assign scb = {regs_q[`VCSC_A_SCL_CB], regs_q[`VCSC_A_SCL_LO][3:2]};
  assign scr = {regs_q[`VCSC_A_SCL_CR], regs_q[`VCSC_A_SCL_LO][5:4]};
  // ----------------------------------------
  // Arithmetic helpers
  // ----------------------------------------
  function automatic logic [7:0] clamp8(input logic signed [23:0] v);
    clamp8 = (v < 0) ? 8'h00 : (v > 24'sd255) ? 8'hff : v[7:0];
  endfunction
  function automatic logic signed [23:0] term(input logic [9:0] k,
                                              input logic signed [23:0] x);
    term = $signed({14'h0, k}) * x;
  endfunction
  function automatic logic signed [23:0] ctr(input logic [7:0] c);
    ctr = $signed({16'h0, c}) - $signed({16'h0, `VCSC_MID});
  endfunction
  function automatic logic signed [23:0] unc(input logic [7:0] c);
    unc = $signed({16'h0, c});
  endfunction
  // YCrCb to RGB; the divide by 315 matches coefficient units.
  function automatic logic [23:0] to_rgb(input logic [23:0] p,
      input logic [9:0] kgy, kgu, kgv, kbu, krv);
    logic signed [23:0] ty;
    ty = term(kgy, unc(p[23:16]));
    to_rgb = {
      clamp8((ty + term(krv, ctr(p[15:8]))) / `VCSC_COEF_UNITY),
      clamp8((ty - term(kgu, ctr(p[7:0])) - term(kgv, ctr(p[15:8])))
             / `VCSC_COEF_UNITY),
      clamp8((ty + term(kbu, ctr(p[7:0]))) / `VCSC_COEF_UNITY)};
  endfunction
  // RGB to YCrCb in integers, with its own luma weights 77, 150 and 29 over 256.
  function automatic logic [23:0] to_ycc(input logic [23:0] p);
    logic signed [23:0] r, g, b, y;
    r = unc(p[23:16]);
    g = unc(p[15:8]);
    b = unc(p[7:0]);
    y = (24'sd77 * r + 24'sd150 * g + 24'sd29 * b) >>> 8;
    to_ycc = {clamp8(y),
              clamp8(((r - y) * 24'sd145 >>> 8) + 24'sd128),
              clamp8(((b - y) * 24'sd126 >>> 8) + 24'sd128)};
  endfunction
  function automatic logic [7:0] scl(input logic [7:0] c, input logic [9:0] k,
                                     input logic centred);
    logic signed [23:0] v;
    v = centred ? ctr(c) : unc(c);
    v = term(k, v) >>> `VCSC_SCALE_SHIFT;
    scl = clamp8(centred ? v + unc(`VCSC_MID) : v);
  endfunction
  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  // A stall downstream fills this buffer and then drops pix_ready.
  logic [24:0] buf_q [0:DEPTH-1];
  logic [PW:0] wp_q, rp_q;
  logic [PW:0] wp_d, rp_d;
  logic buf_empty, take, push;
  logic [24:0] head;
  // The extra top bit of each pointer tells a full buffer from an empty one.
  function automatic logic ptr_full(input logic [PW:0] w, input logic [PW:0] r);
    ptr_full = (w[PW] != r[PW]) && (w[PW-1:0] == r[PW-1:0]);
  endfunction
  assign buf_empty = wp_q == rp_q;
  // Ready promises room one edge ahead, so only the handshake may push.
  assign push = bus.pix_valid && bus.pix_ready;
  assign take = !buf_empty && (!out_valid || out_ready);
  assign wp_d = wp_q + (PW + 1)'(push);
  assign rp_d = rp_q + (PW + 1)'(take);
  assign head = buf_q[rp_q[PW-1:0]];
  always_ff @(posedge bus.clk) begin
    if (push) begin
      buf_q[wp_q[PW-1:0]] <= {bus.pix_active, bus.pix_data};
    end
  end
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
      bus.pix_ready <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      bus.pix_ready <= !ptr_full(wp_d, rp_d);
    end
  end
  // ----------------------------------------
  // Conversion datapath
  // ----------------------------------------
  logic [23:0] sd_in, sd_sc, res;
  logic res_rgb;
  assign sd_in = sd_rgb_in ? to_ycc(head[23:0]) : head[23:0];
  assign sd_sc = {scl(sd_in[23:16], sy, 1'b0), scl(sd_in[15:8], scr, 1'b1),
                  scl(sd_in[7:0], scb, 1'b1)};
  always_comb begin
    res = head[23:0];
    res_rgb = 1'b0;
    if (sd_mode) begin
      res_rgb = !out_yprpb;
      res = out_yprpb ? sd_sc : to_rgb(sd_sc, {`VCSC_R_GY_HI, 2'h3},
        {`VCSC_R_GU_HI, 2'h3}, {`VCSC_R_GV_HI, 2'h3},
        {`VCSC_R_BU_HI, 2'h0}, {`VCSC_R_RV_HI, 2'h0});
    end else if (pat_en) begin
      res = {regs_q[`VCSC_A_PAT0], regs_q[`VCSC_A_PAT1],
             regs_q[`VCSC_A_PAT2]};
    end else if (ed_rgb_in) begin
      res_rgb = 1'b1;
    end else if (!out_yprpb) begin
      res_rgb = 1'b1;
      res = manual ? to_rgb(head[23:0], gy, gu, gv, bu, rv) :
        to_rgb(head[23:0], {`VCSC_R_GY_HI, 2'h3}, {`VCSC_R_GU_HI, 2'h3},
               {`VCSC_R_GV_HI, 2'h3}, {`VCSC_R_BU_HI, 2'h0},
               {`VCSC_R_RV_HI, 2'h0});
    end else if (manual) begin
      res = {clamp8(term(gy, unc(head[23:16])) / `VCSC_COEF_UNITY),
             clamp8(term(rv, ctr(head[15:8])) / `VCSC_COEF_UNITY + 24'sd128),
             clamp8(term(bu, ctr(head[7:0])) / `VCSC_COEF_UNITY + 24'sd128)};
    end
  end
  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      out_valid <= 1'b0;
      out_data <= 24'h0;
      out_is_rgb <= 1'b0;
      sd_ycc <= 24'h0;
      hue_step <= 8'h0;
    end else if (!out_valid || out_ready) begin
      out_valid <= !buf_empty;
      if (take) begin
        out_data <= res;
        out_is_rgb <= res_rgb;
        sd_ycc <= sd_mode ? sd_sc : 24'h0;
        // Offset from 0x80 in steps of 0.17578125 degree
        hue_step <= (sd_mode && hue_en && head[24]) ?
          regs_q[`VCSC_A_HUE] - `VCSC_MID : 8'h00;
      end
    end
  end
endmodule

// ---- verilog/vcsc_source.sv ----
// Pixel source and register programmer facing the colour stage.
// Assumes a user that issues one command at a time on a strobe.
`timescale 1ns/100ps
`include "vcsc_defs.svh"
module vcsc_source (
  vcsc_if.source bus,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic cmd_manual_rgb,
  input wire logic cmd_sync_rgb,
  input wire logic pal_mode,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  output logic cmd_busy,
  output logic [7:0] rd_data,
  output logic rd_done,
  input wire logic in_valid,
  input wire logic in_active,
  input wire logic [23:0] in_data,
  output logic in_ready
);
  vcsc_pkg::vcsc_src_state_type st_q;
  logic [1:0] step_q;
  logic opt_q;
  logic [7:0] outctl_q, edctl_q;
  logic [7:0] seq_addr, seq_data;
  // Manual RGB set-up order
  always_comb begin
    case (step_q)
      2'h0: begin
        seq_addr = `VCSC_A_OUTCTL;
        seq_data = outctl_q | (8'h01 << `VCSC_B_MANUAL);
      end
      2'h1: begin
        seq_addr = `VCSC_A_OUTCTL;
        seq_data = outctl_q & ~(8'h01 << `VCSC_B_OUT_YPRPB);
      end
      2'h2: begin
        seq_addr = `VCSC_A_EDCTL;
        seq_data = edctl_q & ~(8'h01 << `VCSC_B_SYNC_PRPB);
      end
      default: begin
        seq_addr = `VCSC_A_OUTCTL;
        seq_data = outctl_q | (8'h01 << `VCSC_B_SYNC_RGB);
      end
    endcase
  end
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      st_q <= vcsc_pkg::VCSC_SRC_IDLE;
      step_q <= 2'h0;
      opt_q <= 1'b0;
      outctl_q <= 8'h00;
      edctl_q <= 8'h00;
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      bus.reg_addr <= 8'h00;
      bus.reg_wdata <= 8'h00;
      cmd_busy <= 1'b0;
      rd_data <= 8'h00;
      rd_done <= 1'b0;
    end else begin
      bus.reg_wr <= 1'b0;
      bus.reg_rd <= 1'b0;
      rd_done <= 1'b0;
      case (st_q)
        vcsc_pkg::VCSC_SRC_IDLE: begin
          cmd_busy <= cmd_wr || cmd_rd || cmd_manual_rgb;
          if (cmd_manual_rgb) begin
            opt_q <= cmd_sync_rgb;
            step_q <= 2'h0;
            st_q <= vcsc_pkg::VCSC_SRC_SEQ;
          end else if (cmd_wr) begin
            bus.reg_wr <= 1'b1;
            bus.reg_addr <= cmd_addr;
            // PAL cannot reach below 0x01
            bus.reg_wdata <= (cmd_addr == `VCSC_A_HUE && pal_mode &&
                              cmd_data < `VCSC_PAL_HUE_MIN) ?
                             `VCSC_PAL_HUE_MIN : cmd_data;
            if (cmd_addr == `VCSC_A_OUTCTL) begin
              outctl_q <= cmd_data;
            end
            if (cmd_addr == `VCSC_A_EDCTL) begin
              edctl_q <= cmd_data;
            end
            st_q <= vcsc_pkg::VCSC_SRC_WRITE;
          end else if (cmd_rd) begin
            bus.reg_rd <= 1'b1;
            bus.reg_addr <= cmd_addr;
            st_q <= vcsc_pkg::VCSC_SRC_READ;
          end
        end
        vcsc_pkg::VCSC_SRC_WRITE: begin
          cmd_busy <= 1'b0;
          st_q <= vcsc_pkg::VCSC_SRC_IDLE;
        end
        vcsc_pkg::VCSC_SRC_SEQ: begin
          bus.reg_wr <= 1'b1;
          bus.reg_addr <= seq_addr;
          bus.reg_wdata <= seq_data;
          if (seq_addr == `VCSC_A_OUTCTL) begin
            outctl_q <= seq_data;
          end else begin
            edctl_q <= seq_data;
          end
          step_q <= step_q + 2'h1;
          if (step_q == 2'h3 || (step_q == 2'h2 && !opt_q)) begin
            st_q <= vcsc_pkg::VCSC_SRC_WRITE;
          end
        end
        vcsc_pkg::VCSC_SRC_READ: begin
          st_q <= vcsc_pkg::VCSC_SRC_WAIT;
        end
        vcsc_pkg::VCSC_SRC_WAIT: begin
          rd_data <= bus.reg_rdata;
          rd_done <= 1'b1;
          cmd_busy <= 1'b0;
          st_q <= vcsc_pkg::VCSC_SRC_IDLE;
        end
        default: begin
          st_q <= vcsc_pkg::VCSC_SRC_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Pixel forwarding
  // ----------------------------------------
  // One stage; ready is offered only when the stage will be empty, since
  // the far side's ready for the next edge is not known yet. This halves
  // the pixel rate, which is traded for never dropping a word.
  logic stage_load, stage_full_d;
  assign stage_load = !bus.pix_valid || bus.pix_ready;
  assign stage_full_d = stage_load ? (in_valid && in_ready) : bus.pix_valid;
  always_ff @(posedge bus.clk or negedge bus.rst_b) begin
    if (!bus.rst_b) begin
      bus.pix_valid <= 1'b0;
      bus.pix_active <= 1'b0;
      bus.pix_data <= 24'h0;
      in_ready <= 1'b0;
    end else begin
      bus.pix_valid <= stage_full_d;
      if (stage_load) begin
        bus.pix_active <= in_active;
        bus.pix_data <= in_data;
      end
      in_ready <= !stage_full_d;
    end
  end
endmodule

// ---- verif/vcsc_assertions.sv ----
// Checker for the link between the pixel source and the colour stage.
// Assumes it is instantiated beside the interface, on its plain signals.
`timescale 1ns/100ps
module vcsc_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic pix_active,
  input wire logic [23:0] pix_data
);
  // ----------------------------------------
  // Shadow registers
  // ----------------------------------------
  // Shadows follow the wire, so a clamp made by the source is seen too.
  logic [7:0] hue_q;
  logic [7:0] lo_q;
  logic [7:0] gy_lo_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hue_q <= 8'h80;
      lo_q <= 8'h00;
      gy_lo_q <= 8'h03;
    end else if (reg_wr) begin
      if (reg_addr == 8'ha0) hue_q <= reg_wdata;
      if (reg_addr == 8'h9c) lo_q <= reg_wdata;
      if (reg_addr == 8'h03) gy_lo_q <= reg_wdata;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RVALID_AFTER_RD: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  AST_RVALID_CAUSED: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  AST_HUE_READBACK: assert property (
    reg_rd && reg_addr == 8'ha0 |=> reg_rdata == $past(hue_q))
    else $error("hue register readback wrong");
  AST_SCALE_LO_READBACK: assert property (
    reg_rd && reg_addr == 8'h9c |=> reg_rdata == $past(lo_q))
    else $error("shared scale low bits readback wrong");
  AST_GY_LO_READBACK: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rdata == $past(gy_lo_q))
    else $error("luma gain low bits readback wrong");
  AST_UNMAPPED_ZERO: assert property (
    reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_PIX_HOLD: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data)
      && $stable(pix_active))
    else $error("pixel changed while refused");
  AST_MANUAL_SEQ: assert property (
    reg_wr && reg_addr == 8'h02 && reg_wdata[3] && !reg_wdata[5]
      && $past(reg_wr && reg_addr == 8'h02)
      |=> reg_wr && reg_addr == 8'h35 && !reg_wdata[2])
    else $error("manual matrix write order broken");
  cover property (reg_wr && reg_addr == 8'h35 && $past(reg_wr));
  cover property (pix_valid && !pix_ready);
  cover property (reg_rd && reg_addr == 8'ha0);
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench joining the pixel source and the colour stage.
// Assumes the design files are compiled first; one 250 MHz clock.
`timescale 1ns/100ps
module testbench;
  logic clk, rst_b, cmd_wr, cmd_rd, cmd_manual_rgb, cmd_sync_rgb, pal_mode;
  logic in_valid, in_active, out_ready, cmd_busy, rd_done, in_ready;
  logic out_valid, out_is_rgb, o_rgb;
  logic [7:0] cmd_addr, cmd_data, rd_data, hue_step, o_hue;
  logic [23:0] in_data, out_data, sd_ycc, o_data, o_sd;
  logic [7:0] rst_tab [7] = '{8'h03, 8'hf0, 8'h4e, 8'h0e, 8'h24, 8'h92,
    8'h7c};
  int n_mismatch, comparisons, n, k;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  vcsc_if link (.clk(clk), .rst_b(rst_b));
  vcsc_core #(.DEPTH(2)) i_vcsc_core (.bus(link.device),
    .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
    .out_is_rgb(out_is_rgb), .sd_ycc(sd_ycc), .hue_step(hue_step));
  vcsc_source i_vcsc_source (.bus(link.source), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_manual_rgb(cmd_manual_rgb),
    .cmd_sync_rgb(cmd_sync_rgb), .pal_mode(pal_mode), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_busy(cmd_busy), .rd_data(rd_data),
    .rd_done(rd_done), .in_valid(in_valid), .in_active(in_active),
    .in_data(in_data), .in_ready(in_ready));
  vcsc_assertions i_vcsc_assertions (.clk(link.clk), .rst_b(link.rst_b),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_rvalid(link.reg_rvalid), .pix_valid(link.pix_valid),
    .pix_ready(link.pix_ready), .pix_active(link.pix_active),
    .pix_data(link.pix_data));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // All command tasks are entered and left at a falling edge.
  task automatic wait_idle();
    int i;
    i = 0;
    while (cmd_busy !== 1'b0 && i < 50) begin
      @(negedge clk);
      i++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cmd_addr = a;
    cmd_data = d;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    repeat (2) @(negedge clk);
    wait_idle();
  endtask
  task automatic manual_rgb();
    cmd_manual_rgb = 1'b1;
    @(negedge clk);
    cmd_manual_rgb = 1'b0;
    repeat (2) @(negedge clk);
    wait_idle();
    repeat (4) @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    int i;
    cmd_addr = a;
    cmd_rd = 1'b1;
    @(negedge clk);
    cmd_rd = 1'b0;
    i = 0;
    while (rd_done !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    check(rd_data, exp);
    @(negedge clk);
    wait_idle();
  endtask
  task automatic wait_out();
    int i;
    i = 0;
    while (out_valid !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    o_data = out_data;
    o_rgb = out_is_rgb;
    o_sd = sd_ycc;
    o_hue = hue_step;
    @(negedge clk);
  endtask
  task automatic pix(input logic [23:0] d, input logic act);
    int i;
    in_data = d;
    in_active = act;
    in_valid = 1'b1;
    i = 0;
    while (in_ready !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    in_valid = 1'b0;
    wait_out();
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    {cmd_wr, cmd_rd, cmd_manual_rgb, cmd_sync_rgb, pal_mode} = 5'h00;
    {in_valid, in_active, cmd_addr, cmd_data, in_data} = 42'h0;
    out_ready = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    rst_b = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (k = 0; k < 7; k++) rdc(8'h03 + k[7:0], rst_tab[k]);
    rdc(8'h02, 8'h00);
    rdc(8'h10, 8'h00);
    pal_mode = 1'b1;
    wr(8'ha0, 8'h00);
    rdc(8'ha0, 8'h01);
    pal_mode = 1'b0;
    wr(8'ha0, 8'h00);
    rdc(8'ha0, 8'h00);
    wr(8'h01, 8'h10);
    wr(8'h02, 8'h20);
    // A stalled receiver must fill the pipe, refuse, then lose nothing.
    out_ready = 1'b0;
    n = 0;
    in_valid = 1'b1;
    for (k = 0; k < 12; k++) begin
      in_data = {8'h10 + n[7:0], 16'h8080};
      if (in_ready === 1'b1) n++;
      @(negedge clk);
    end
    in_valid = 1'b0;
    check(24'(n < 12), 24'h1);
    out_ready = 1'b1;
    for (k = 0; k < n; k++) begin
      wait_out();
      check(o_data, {8'h10 + k[7:0], 16'h8080});
    end
    wr(8'h35, 8'h02);
    pix(24'h123456, 1'b1);
    check(o_data, 24'h123456);
    check(o_rgb, 1'b1);
    wr(8'h35, 8'h04);
    wr(8'h05, 8'h9d);
    wr(8'h03, 8'h02);
    wr(8'h02, 8'h28);
    pix(24'h408080, 1'b1);
    check(o_data[23:16], 8'h80);
    wr(8'h36, 8'heb);
    wr(8'h37, 8'h80);
    wr(8'h38, 8'h80);
    wr(8'h31, 8'h04);
    pix(24'h112233, 1'b1);
    check(o_data, 24'heb8080);
    check(o_rgb, 1'b0);
    wr(8'h31, 8'h00);
    cmd_sync_rgb = 1'b1;
    manual_rgb();
    rdc(8'h02, 8'h18);
    rdc(8'h35, 8'h00);
    pix(24'h508080, 1'b1);
    check(o_data, 24'ha0a0a0);
    check(o_rgb, 1'b1);
    wr(8'h01, 8'h00);
    wr(8'h87, 8'h04);
    wr(8'ha0, 8'h97);
    wr(8'h9d, 8'h55);
    wr(8'h9c, 8'h03);
    pix(24'hc08080, 1'b1);
    check(o_sd[23:16], 8'h80);
    check(o_hue, 8'h17);
    pix(24'hc08080, 1'b0);
    check(o_hue, 8'h00);
    wr(8'h87, 8'h80);
    pix(24'h808080, 1'b1);
    check(o_sd, 24'h558080);
    check(o_rgb, 1'b1);
    check(o_hue, 8'h00);
    rdc(8'h9c, 8'h03);
    report_and_stop();
  end
endmodule
